/* File: dc_brake_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the DC brake sequencer.
// Assumes: 125 MHz system clock.
// Notes: Included by the design and by the testbench.
`ifndef DC_BRAKE_DEFINES_SVH
`define DC_BRAKE_DEFINES_SVH
`define CLK_FREQ_HZ 125000000
`define BRAKE_DURATION_DEFAULT_MS 1000
`define BRAKE_DURATION_DEFAULT_CYC ((`CLK_FREQ_HZ / 1000) * `BRAKE_DURATION_DEFAULT_MS)
`define DEMAG_DEFAULT_MS 100
`define DEMAG_DEFAULT_CYC ((`CLK_FREQ_HZ / 1000) * `DEMAG_DEFAULT_MS)
`define ADDR_CTRL 8'h00
`define ADDR_DURATION 8'h04
`define ADDR_DEMAG 8'h08
`define ADDR_START_SPEED 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_SPEED 8'h14
`define CTRL_MODE_LSB 0
`define CTRL_ACT_BIT 8
`define CTRL_SRC_BIT 9
`define MODE_OFF 8'h00
`define MODE_GENERAL 8'h04
`define MODE_STOP 8'h05
`define MODE_SPEED 8'h0e
`define STAT_ACT_BIT 11
`define START_SPEED_DEFAULT 32'h00000000
`define DIN_BRAKE_BIT 3
`endif

/* File: dc_brake_pkg.sv */
// Purpose: Types shared by the DC brake sequencer.
// Assumes: Nothing beyond the defines header.
// Notes: Holds the state enumeration.
package dc_brake_pkg;
    typedef enum logic [2:0] {
        ST_RUN,
        ST_RAMP,
        ST_DEMAG,
        ST_INJECT,
        ST_COAST
    } brake_state_e;
endpackage : dc_brake_pkg

/* File: dc_braking_sequencer.sv */
// Purpose: Decides when the drive applies DC braking and when it returns to normal operation.
// Assumes: Classic Wishbone slave, one clock, synchronous active-low reset.
// Notes: Registers: control, duration, demag time, start speed, status, speed readback.
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "dc_brake_defines.svh"
module dc_braking_sequencer
    import dc_brake_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [31:0] motor_speed_i,
    input wire logic induction_motor_i,
    input wire logic [15:0] digital_input_word_i,
    input wire logic fault_brake_i,
    input wire logic ramp_stop_cmd_i,
    input wire logic fast_stop_cmd_i,
    output logic ramp_down_o,
    output logic coast_stop_cmd_o,
    output logic brake_current_en_o,
    output logic brake_active_o
);

    logic [7:0] brake_mode_select_reg;
    logic brake_activate_reg;
    logic brake_activate_source_reg;
    logic [31:0] brake_duration_setting_reg;
    logic [31:0] demag_time_reg;
    logic [31:0] brake_start_speed_reg;
    logic [31:0] count_reg;
    logic armed_reg;
    logic from_stop_reg;
    logic from_fault_reg;
    brake_state_e state_reg;
    logic act_in;
    logic above;
    logic below;
    logic wr;
    logic stop_cmd;

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic mode_ok(input logic [7:0] m);
        return (m == `MODE_OFF) || (m == `MODE_GENERAL) || (m == `MODE_STOP) ||
               (m == `MODE_SPEED);
    endfunction : mode_ok

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign act_in = brake_activate_source_reg ? digital_input_word_i[`DIN_BRAKE_BIT]
                                              : brake_activate_reg;
    assign above = motor_speed_i > brake_start_speed_reg;
    assign below = motor_speed_i < brake_start_speed_reg;
    assign stop_cmd = ramp_stop_cmd_i || fast_stop_cmd_i;

    // Bus acknowledge, one cycle after the request, dropped the cycle after.
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Configuration registers.
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            brake_mode_select_reg <= `MODE_OFF;
            brake_activate_reg <= 1'b0;
            brake_activate_source_reg <= 1'b0;
            brake_duration_setting_reg <= 32'(`BRAKE_DURATION_DEFAULT_CYC);
            demag_time_reg <= 32'(`DEMAG_DEFAULT_CYC);
            brake_start_speed_reg <= `START_SPEED_DEFAULT;
        end else if (wr) begin
            unique case (wb_adr_i)
                `ADDR_CTRL: begin
                    if (wb_sel_i[0] && mode_ok(wb_dat_i[7:0])
                        && (induction_motor_i || wb_dat_i[7:0] == `MODE_OFF)) begin
                        brake_mode_select_reg <= wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        brake_activate_reg <= wb_dat_i[`CTRL_ACT_BIT];
                        brake_activate_source_reg <= wb_dat_i[`CTRL_SRC_BIT];
                    end
                end
                `ADDR_DURATION: begin
                    brake_duration_setting_reg <= merge(brake_duration_setting_reg,
                                                        wb_dat_i, wb_sel_i);
                end
                `ADDR_DEMAG: begin
                    demag_time_reg <= merge(demag_time_reg, wb_dat_i, wb_sel_i);
                end
                `ADDR_START_SPEED: begin
                    brake_start_speed_reg <= merge(brake_start_speed_reg, wb_dat_i, wb_sel_i);
                end
                default: begin
                end
            endcase
        end
    end

    // Read data.
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
            unique case (wb_adr_i)
                `ADDR_CTRL: wb_dat_o <= {22'h000000, brake_activate_source_reg,
                                         brake_activate_reg, brake_mode_select_reg};
                `ADDR_DURATION: wb_dat_o <= brake_duration_setting_reg;
                `ADDR_DEMAG: wb_dat_o <= demag_time_reg;
                `ADDR_START_SPEED: wb_dat_o <= brake_start_speed_reg;
                `ADDR_STATUS: wb_dat_o <= {20'h00000, act_in, 8'h00, 3'(state_reg)};
                `ADDR_SPEED: wb_dat_o <= motor_speed_i;
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // Arming for the speed threshold mode: speed must first exceed the start speed.
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            armed_reg <= 1'b0;
        end else if (above) begin
            armed_reg <= 1'b1;
        end else if (state_reg == ST_DEMAG) begin
            armed_reg <= 1'b0;
        end
    end

    // Braking sequence.
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_reg <= ST_RUN;
            count_reg <= 32'h00000000;
            from_stop_reg <= 1'b0;
            from_fault_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_RUN: begin
                    count_reg <= demag_time_reg;
                    from_stop_reg <= 1'b0;
                    from_fault_reg <= 1'b0;
                    if (brake_mode_select_reg != `MODE_OFF) begin
                        if (fault_brake_i) begin
                            state_reg <= ST_RAMP;
                            from_fault_reg <= 1'b1;
                        end else if (stop_cmd && (brake_mode_select_reg == `MODE_STOP ||
                                                  act_in)) begin
                            state_reg <= ST_RAMP;
                            from_stop_reg <= 1'b1;
                        end else if (brake_mode_select_reg == `MODE_SPEED) begin
                            if (armed_reg && below && act_in) begin
                                state_reg <= ST_DEMAG;
                            end
                        end else if (brake_mode_select_reg == `MODE_GENERAL && act_in) begin
                            state_reg <= ST_DEMAG;
                        end
                    end
                end
                ST_RAMP: begin
                    count_reg <= demag_time_reg;
                    if (!below && motor_speed_i != brake_start_speed_reg) begin
                        state_reg <= ST_RAMP;
                    end else begin
                        state_reg <= ST_DEMAG;
                    end
                end
                ST_DEMAG: begin
                    if (count_reg <= 32'h00000001) begin
                        count_reg <= brake_duration_setting_reg;
                        state_reg <= ST_INJECT;
                    end else begin
                        count_reg <= count_reg - 32'h00000001;
                    end
                end
                ST_INJECT: begin
                    if (count_reg <= 32'h00000001) begin
                        state_reg <= (from_stop_reg || from_fault_reg) ? ST_COAST
                                                                        : ST_RUN;
                    end else if (!from_stop_reg && !from_fault_reg && !act_in) begin
                        state_reg <= ST_RUN;
                    end else begin
                        count_reg <= count_reg - 32'h00000001;
                    end
                end
                ST_COAST: begin
                    if (!stop_cmd && !fault_brake_i) begin
                        state_reg <= ST_RUN;
                    end
                end
                default: begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end

    // Outputs to the power stage and ramp generator.
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ramp_down_o <= 1'b0;
            coast_stop_cmd_o <= 1'b0;
            brake_current_en_o <= 1'b0;
            brake_active_o <= 1'b0;
        end else begin
            ramp_down_o <= (state_reg == ST_RAMP);
            coast_stop_cmd_o <= (state_reg == ST_DEMAG) || (state_reg == ST_COAST);
            brake_current_en_o <= (state_reg == ST_INJECT);
            brake_active_o <= (state_reg == ST_DEMAG) || (state_reg == ST_INJECT);
        end
    end

endmodule : dc_braking_sequencer

/* File: brake_seq_checker.sv */
// Purpose: Port-level checks of the DC brake sequencer.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every sequencer instance.
`timescale 1ns/1ps
module brake_seq_checker (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic ramp_down_o,
    input wire logic coast_stop_cmd_o,
    input wire logic brake_current_en_o,
    input wire logic brake_active_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    inject_alone_a: assert property (brake_current_en_o |-> !coast_stop_cmd_o && !ramp_down_o)
        else $error("inject overlaps coast or ramp");
    demag_first_a: assert property ($rose(brake_current_en_o) |-> $past(coast_stop_cmd_o))
        else $error("inject without demag");
    inject_active_a: assert property (brake_current_en_o |-> brake_active_o)
        else $error("inject not flagged active");
    demag_hold_a: assert property ($rose(brake_active_o) |-> coast_stop_cmd_o [*3])
        else $error("demag phase too short");
    ramp_then_a: assert property ($fell(ramp_down_o) |-> brake_active_o)
        else $error("ramp not followed by braking");
    inject_end_a: assert property ($fell(brake_current_en_o) |-> !brake_active_o)
        else $error("active left after inject");
    cover property ($rose(brake_current_en_o));
    cover property ($fell(ramp_down_o));
    cover property ($fell(brake_current_en_o) && coast_stop_cmd_o);
endmodule : brake_seq_checker
bind dc_braking_sequencer brake_seq_checker chk_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ramp_down_o(ramp_down_o),
    .coast_stop_cmd_o(coast_stop_cmd_o), .brake_current_en_o(brake_current_en_o),
    .brake_active_o(brake_active_o));

/* File: motor_plant.sv */
// Purpose: Shaft speed model of the motor power stage.
// Assumes: Speed moves by four units a cycle.
// Notes: Braking, ramping and coasting slow the shaft.
`timescale 1ns/1ps
module motor_plant (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ramp_i,
    input wire logic brake_i,
    input wire logic coast_i,
    input wire logic [31:0] set_i,
    output logic [31:0] speed_o
);
    // Speed falls by four units a cycle across braking, as flying restart would see it.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            speed_o <= 32'h0;
        end else if (ramp_i || brake_i || coast_i || speed_o > set_i) begin
            speed_o <= (speed_o > 32'h4) ? speed_o - 32'h4 : 32'h0;
        end else if (speed_o < set_i) begin
            speed_o <= speed_o + 32'h4;
        end
    end
endmodule : motor_plant

/* File: tb_dc_braking_sequencer.sv */
// Purpose: Bus-driven scenarios for the DC brake sequencer.
// Assumes: Counts are shortened over the bus.
// Notes: Shaft speed comes from the plant model.
`timescale 1ns/1ps
`include "dc_brake_defines.svh"
module tb_dc_braking_sequencer;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic ind = 1'b0;
    logic [2:0] trg = 3'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] setp = 32'h0;
    logic [15:0] din = 16'h0;
    logic [31:0] rd;
    logic [31:0] dato;
    logic [31:0] spd;
    logic ack;
    logic [3:0] o;
    logic [7:0] mv[5] = '{8'h04, 8'h03, 8'h05, 8'h0e, 8'h00};
    logic [7:0] me[5] = '{8'h04, 8'h04, 8'h05, 8'h0e, 8'h00};
    int mismatches = 0;
    int compares = 0;
    always #4 clk = ~clk;
    dc_braking_sequencer dut_u (.ref_clk_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hf), .wb_dat_o(dato),
        .wb_ack_o(ack), .motor_speed_i(spd), .induction_motor_i(ind),
        .digital_input_word_i(din), .fault_brake_i(trg[2]), .ramp_stop_cmd_i(trg[0]),
        .fast_stop_cmd_i(trg[1]), .ramp_down_o(o[0]), .coast_stop_cmd_o(o[1]),
        .brake_current_en_o(o[2]), .brake_active_o(o[3]));
    motor_plant plant_u (.clk_i(clk), .rstn_i(rstn), .ramp_i(o[0]), .brake_i(o[2]),
        .coast_i(o[1]), .set_i(setp), .speed_o(spd));
    task automatic tally_and_finish();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dato;
        cyc <= 1'b0;
        if (ack !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
    endtask : bus
    task automatic wt(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while (o[k] !== v) begin
            @(posedge clk);
            n++;
            if (n > lim) begin
                mismatches++;
                tally_and_finish();
            end
        end
    endtask : wt
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, `ADDR_DURATION, 32'h0);
        chk(rd, 32'h07735940);
        bus(1'b0, `ADDR_DEMAG, 32'h0);
        chk(rd, 32'h00bebc20);
        bus(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, `ADDR_CTRL, 32'h4);
        bus(1'b0, `ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        ind <= 1'b1;
        foreach (mv[i]) begin
            bus(1'b1, `ADDR_CTRL, {24'h0, mv[i]});
            bus(1'b0, `ADDR_CTRL, 32'h0);
            chk(rd, {24'h0, me[i]});
        end
        bus(1'b1, `ADDR_DEMAG, 32'h5);
        bus(1'b1, `ADDR_START_SPEED, 32'h64);
        bus(1'b1, `ADDR_DURATION, 32'hc8);
        bus(1'b1, `ADDR_CTRL, 32'h204);
        din <= 16'h0008;
        wt(2, 1'b1, 40);
        bus(1'b0, `ADDR_STATUS, 32'h0);
        chk({28'h0, rd[11], rd[2:0]}, 32'hb);
        bus(1'b0, `ADDR_SPEED, 32'h0);
        chk(rd, 32'h0);
        din <= 16'h0;
        wt(2, 1'b0, 60);
        chk({28'h0, o}, 32'h0);
        bus(1'b1, `ADDR_CTRL, 32'h10e);
        repeat (20) @(posedge clk);
        chk({28'h0, o}, 32'h0);
        setp <= 32'h12c;
        repeat (90) @(posedge clk);
        setp <= 32'h0;
        wt(2, 1'b1, 120);
        bus(1'b1, `ADDR_CTRL, 32'h00e);
        wt(2, 1'b0, 60);
        bus(1'b1, `ADDR_DURATION, 32'h8);
        bus(1'b1, `ADDR_CTRL, 32'h10e);
        // Braking cleared the arming, so the shaft must pass the start speed again.
        setp <= 32'h12c;
        repeat (90) @(posedge clk);
        setp <= 32'h0;
        wt(2, 1'b1, 120);
        wt(2, 1'b0, 30);
        chk({28'h0, o}, 32'h0);
        bus(1'b1, `ADDR_CTRL, 32'h00e);
        wt(3, 1'b0, 40);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, `ADDR_CTRL, (i == 2) ? 32'h004 : 32'h005);
            setp <= 32'h12c;
            repeat (90) @(posedge clk);
            trg <= 3'h1 << i;
            wt(0, 1'b1, 20);
            wt(0, 1'b0, 80);
            wt(2, 1'b1, 20);
            wt(2, 1'b0, 20);
            chk({28'h0, o}, 32'h2);
            trg <= 3'h0;
            setp <= 32'h0;
            wt(1, 1'b0, 20);
        end
        tally_and_finish();
    end
endmodule : tb_dc_braking_sequencer
